// File: hdl/phy_ctrl_pkg.sv
// Shared constants for the transceiver reset, power and pin-mode block.
// Assumes one 40 MHz system clock; all pins arrive synchronous to it.
package phy_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port geometry and map
  localparam int          ADDR_W          = 5;
  localparam int          DATA_W          = 16;
  localparam logic [4:0]  REG_CONTROL     = 5'h00;
  localparam logic [4:0]  REG_LAMP_CFG    = 5'h01;
  localparam logic [4:0]  REG_HW_CFG      = 5'h02;
  localparam logic [4:0]  REG_STATUS      = 5'h03;

  // Control register fields
  localparam int          CTL_SOFT_RESET  = 15;
  localparam int          CTL_SOFT_PWRDN  = 11;
  localparam int          CTL_ISOLATE     = 10;

  // Lamp configuration fields: lamp n selector at LAMP_SEL_LSB + 4*n
  localparam int          LAMP_COUNT      = 3;
  localparam int          LAMP_SEL_W      = 3;
  localparam int          LAMP_SEL_LSB    = 0;
  localparam int          LAMP_SEL_STEP   = 4;
  localparam logic [2:0]  LAMP_SEL_RESET  = 3'h0;
  localparam int          COND_W          = 8;

  // Status register fields
  localparam int          STS_MODE_LSB    = 0;
  localparam int          STS_PAUSE       = 4;
  localparam int          STS_MGMT_DIS    = 5;
  localparam int          STS_CFG_LSB     = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int          CLK_PERIOD_PS   = 25000;
  localparam int          RESET_STRETCH_NS = 258000;
  localparam int          RESET_STRETCH_CYCLES =
    (RESET_STRETCH_NS * 1000) / CLK_PERIOD_PS;
  localparam int          STRETCH_CNT_W   = 14;

  ////////////////////////////////////////////////////////////////////////////
  // Operating modes, Gray coded along reset -> stretch -> run -> pin down
  typedef enum logic [1:0] {
    ST_RESET   = 2'b00,
    ST_STRETCH = 2'b01,
    ST_RUN     = 2'b11,
    ST_PIN_PD  = 2'b10
  } mode_type;

endpackage

// File: hdl/scan_edge_path.sv
// Boundary-scan data path timed by the test clock edges.
// Assumes the test clock, data and test reset are sampled by clk.
module scan_edge_path (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Test port
  input  wire logic testClk,
  input  wire logic testDataIn,
  input  wire logic testModeSel,
  input  wire logic testResetN,
  output logic      testDataOut
);
  import phy_ctrl_pkg::*;

  typedef struct packed {
    logic testClk;
    logic capture;
    logic dataOut;
  } scan_type;

  scan_type r;
  scan_type n;
  logic     rise;
  logic     fall;

  assign rise = testClk && !r.testClk;
  assign fall = !testClk && r.testClk;

  always_comb begin
    n         = r;
    n.testClk = testClk;
    if (!testResetN) begin
      n.capture = 1'b0;
      n.dataOut = 1'b0;
    end else begin
      if (rise && !testModeSel) begin
        n.capture = testDataIn;
      end
      if (fall) begin
        n.dataOut = r.capture;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign testDataOut = r.dataOut;

  ////////////////////////////////////////////////////////////////////////////
  AST_TDI_ON_RISE: assert property (@(posedge clk) disable iff (!reset_n)
    rise && !testModeSel && testResetN |=> r.capture == $past(testDataIn))
    else $error("test data not captured on rising test clock");
  AST_TDO_ON_FALL: assert property (@(posedge clk) disable iff (!reset_n)
    !fall && testResetN |=> $stable(testDataOut))
    else $error("test data output moved away from a falling edge");
  AST_TEST_RESET: assert property (@(posedge clk) disable iff (!reset_n)
    !testResetN |=> !testDataOut && !r.capture)
    else $error("test reset did not clear scan logic");

endmodule

// File: hdl/phy_reset_power_pin_modes.sv
// Reset sequencing, power-down handling, lamp/configuration pins and
// media-interface pin modes for a single-port 10/100 transceiver.
// Assumes every pin input is synchronous to clk; the core data path and
// the lamp status conditions are supplied by neighbouring logic.
//
// Our own choices: the register offsets and the strobed register port.
module phy_reset_power_pin_modes #(
  parameter int STRETCH_CYCLES = phy_ctrl_pkg::RESET_STRETCH_CYCLES
) (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  // Register port
  input  wire logic [phy_ctrl_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [phy_ctrl_pkg::DATA_W-1:0]   regWrData,
  input  wire logic                              regWrite,
  input  wire logic                              regRead,
  output logic      [phy_ctrl_pkg::DATA_W-1:0]   regRdData,
  // Device pins
  input  wire logic                              resetPinN,
  input  wire logic                              pausePin,
  input  wire logic                              powerDownPin,
  input  wire logic                              mgmtDisablePin,
  // Lamp / configuration pins
  input  wire logic [2:0]                        lampCfgIn,
  output logic      [2:0]                        lampCfgOut,
  output logic      [2:0]                        lampCfgOe,
  input  wire logic [phy_ctrl_pkg::COND_W-1:0]   lampCond,
  // Core side of the media interface
  input  wire logic [3:0]                        coreRxd,
  input  wire logic                              coreRxDv,
  input  wire logic                              coreRxEr,
  input  wire logic                              coreCol,
  input  wire logic                              coreCrs,
  input  wire logic                              coreTxClk,
  input  wire logic                              coreRxClk,
  // Media interface outputs toward the MAC
  output logic      [3:0]                        rxd,
  output logic                                   rxDv,
  output logic                                   rxEr,
  output logic                                   col,
  output logic                                   crs,
  output logic                                   txClk,
  output logic                                   rxClk,
  output logic                                   miiOutOe,
  output logic                                   miiOutPullDown,
  output logic                                   miiInPullDown,
  // Device state toward the core
  output logic                                   pauseAdvertise,
  output logic      [2:0]                        hwCfg,
  output logic                                   coreResetActive,
  output logic                                   corePowerDown,
  // Boundary-scan port
  input  wire logic                              testClk,
  input  wire logic                              testDataIn,
  input  wire logic                              testModeSel,
  input  wire logic                              testResetN,
  output logic                                   testDataOut
);
  import phy_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    mode_type                               mode;
    logic [STRETCH_CNT_W-1:0]               stretchCnt;
    logic                                   softReset;
    logic                                   softPwrDn;
    logic                                   isolate;
    logic [LAMP_COUNT-1:0][LAMP_SEL_W-1:0]  lampSel;
    logic [2:0]                             hwCfg;
    logic [2:0]                             cfgPins;
    logic                                   mgmtDis;
    logic [DATA_W-1:0]                      rdData;
    logic [3:0]                             rxd;
    logic                                   rxDv;
    logic                                   rxEr;
    logic                                   col;
    logic                                   crs;
    logic                                   txClk;
    logic                                   rxClk;
    logic                                   miiOe;
    logic                                   miiOutPd;
    logic                                   miiInPd;
    logic [2:0]                             lampOut;
    logic [2:0]                             lampOe;
    logic                                   pause;
  } state_type;

  localparam logic [STRETCH_CNT_W-1:0] STRETCH_LOAD =
    STRETCH_CNT_W'(STRETCH_CYCLES - 1);

  state_type              r;
  state_type              n;
  logic                   resetReq;
  logic                   wrCtl;
  logic                   wrLamp;
  logic                   wrCfg;
  logic [LAMP_COUNT-1:0]  lampLevel;
  logic [DATA_W-1:0]      ctlView;
  logic [DATA_W-1:0]      lampView;
  logic [DATA_W-1:0]      statusView;

  // Either source alone holds the device in reset
  assign resetReq = !resetPinN || r.softReset;

  assign wrCtl  = regWrite && (regAddr == REG_CONTROL);
  assign wrLamp = regWrite && (regAddr == REG_LAMP_CFG);
  assign wrCfg  = regWrite && (regAddr == REG_HW_CFG);

  ////////////////////////////////////////////////////////////////////////////
  // Lamp condition selection, one selector per lamp
  genvar g;
  generate
    for (g = 0; g < LAMP_COUNT; g++) begin : gLamp
      assign lampLevel[g] = lampCond[r.lampSel[g]];
      assign lampView[LAMP_SEL_LSB + LAMP_SEL_STEP*g +: LAMP_SEL_STEP] =
        {1'b0, r.lampSel[g]};
    end
  endgenerate
  assign lampView[DATA_W-1:LAMP_COUNT*LAMP_SEL_STEP] = '0;

  always_comb begin
    ctlView                 = '0;
    ctlView[CTL_SOFT_RESET] = r.softReset;
    ctlView[CTL_SOFT_PWRDN] = r.softPwrDn;
    ctlView[CTL_ISOLATE]    = r.isolate;
    statusView              = '0;
    statusView[STS_MODE_LSB +: 2] = r.mode;
    statusView[STS_PAUSE]         = r.pause;
    statusView[STS_MGMT_DIS]      = r.mgmtDis;
    statusView[STS_CFG_LSB +: 3]  = r.cfgPins;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = r;

    // Mode sequencing
    case (r.mode)
      ST_RESET: begin
        n.stretchCnt = STRETCH_LOAD;
        if (!resetReq) begin
          n.mode = ST_STRETCH;
        end
      end
      ST_STRETCH: begin
        if (resetReq) begin
          n.mode = ST_RESET;
        end else if (r.stretchCnt == '0) begin
          n.mode = ST_RUN;
        end else begin
          n.stretchCnt = r.stretchCnt - 1'b1;
        end
      end
      ST_RUN: begin
        if (resetReq) begin
          n.mode = ST_RESET;
        end else if (powerDownPin) begin
          n.mode = ST_PIN_PD;
        end
      end
      ST_PIN_PD: begin
        if (resetReq) begin
          n.mode = ST_RESET;
        end else if (!powerDownPin) begin
          n.mode = ST_RUN;
        end
      end
      default: begin
        n.mode = ST_RESET;
      end
    endcase

    // Control register; the reset cycle restores defaults and clears the
    // self-clearing reset bit, but a write setting it again wins
    if (r.mode == ST_RESET) begin
      n.softReset = 1'b0;
      n.softPwrDn = 1'b0;
      n.isolate   = 1'b0;
      n.lampSel   = {LAMP_COUNT{LAMP_SEL_RESET}};
    end else if (wrCtl) begin
      n.softPwrDn = regWrData[CTL_SOFT_PWRDN];
      n.isolate   = regWrData[CTL_ISOLATE];
    end
    if (wrCtl && regWrData[CTL_SOFT_RESET]) begin
      n.softReset = 1'b1;
    end
    if (wrLamp && r.mode != ST_RESET) begin
      for (int i = 0; i < LAMP_COUNT; i++) begin
        n.lampSel[i] =
          regWrData[LAMP_SEL_LSB + LAMP_SEL_STEP*i +: LAMP_SEL_W];
      end
    end

    // Configuration pins are read once, at the last stretch cycle, so the
    // lamp drivers never fight an external strap resistor while sampling
    if (r.mode == ST_STRETCH && !resetReq && r.stretchCnt == '0) begin
      n.cfgPins = lampCfgIn;
      n.hwCfg   = lampCfgIn;
      n.mgmtDis = mgmtDisablePin;
    end else if (wrCfg && !r.mgmtDis && r.mode != ST_RESET) begin
      n.hwCfg   = regWrData[2:0];
    end

    n.pause = pausePin;

    // Read data stand only in the cycle after the read strobe
    n.rdData = '0;
    if (regRead) begin
      if (regAddr == REG_CONTROL) begin
        n.rdData = ctlView;
      end else if (regAddr == REG_LAMP_CFG) begin
        n.rdData = lampView;
      end else if (regAddr == REG_HW_CFG) begin
        n.rdData = {13'h0000, r.hwCfg};
      end else if (regAddr == REG_STATUS) begin
        n.rdData = statusView;
      end else begin
        n.rdData = '0;
      end
    end

    // Lamp pins are released for sampling throughout the reset cycle
    if (n.mode == ST_RUN || n.mode == ST_PIN_PD) begin
      n.lampOe  = 3'h7;
      n.lampOut = lampLevel;
    end else begin
      n.lampOe  = 3'h0;
      n.lampOut = 3'h0;
    end

    // Media interface pin modes, worked out for the coming mode
    n.rxd      = coreRxd;
    n.rxDv     = coreRxDv;
    n.rxEr     = coreRxEr;
    n.col      = coreCol;
    n.crs      = coreCrs;
    n.txClk    = coreTxClk;
    n.rxClk    = coreRxClk;
    n.miiOe    = 1'b1;
    n.miiOutPd = 1'b0;
    n.miiInPd  = 1'b0;
    if (n.mode == ST_RESET || n.mode == ST_STRETCH) begin
      n.rxd      = 4'h0;
      n.rxDv     = 1'b0;
      n.rxEr     = 1'b0;
      n.col      = 1'b0;
      n.crs      = 1'b0;
      n.txClk    = 1'b1;
      n.rxClk    = 1'b1;
      n.miiInPd  = 1'b1;
    end else if (n.mode == ST_PIN_PD) begin
      n.miiOe    = 1'b0;
      n.rxd      = 4'h0;
      n.rxDv     = 1'b0;
      n.rxEr     = 1'b0;
      n.col      = 1'b0;
      n.crs      = 1'b0;
      n.txClk    = 1'b0;
      n.rxClk    = 1'b0;
    end else if (n.isolate) begin
      n.miiOe    = 1'b0;
      n.miiOutPd = 1'b1;
      n.miiInPd  = 1'b1;
      n.rxd      = 4'h0;
      n.rxDv     = 1'b0;
      n.rxEr     = 1'b0;
      n.col      = 1'b0;
      n.crs      = 1'b0;
      n.txClk    = 1'b0;
      n.rxClk    = 1'b0;
    end else if (n.softPwrDn) begin
      n.rxd      = 4'h0;
      n.rxDv     = 1'b0;
      n.rxEr     = 1'b0;
      n.col      = 1'b0;
      n.crs      = 1'b0;
      n.miiInPd  = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r          <= '0;
      r.mode     <= ST_RESET;
      r.miiOe    <= 1'b1;
      r.miiInPd  <= 1'b1;
      r.txClk    <= 1'b1;
      r.rxClk    <= 1'b1;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign regRdData       = r.rdData;
  assign lampCfgOut      = r.lampOut;
  assign lampCfgOe       = r.lampOe;
  assign rxd             = r.rxd;
  assign rxDv            = r.rxDv;
  assign rxEr            = r.rxEr;
  assign col             = r.col;
  assign crs             = r.crs;
  assign txClk           = r.txClk;
  assign rxClk           = r.rxClk;
  assign miiOutOe        = r.miiOe;
  assign miiOutPullDown  = r.miiOutPd;
  assign miiInPullDown   = r.miiInPd;
  assign pauseAdvertise  = r.pause;
  assign hwCfg           = r.hwCfg;
  assign coreResetActive = (r.mode == ST_RESET) || (r.mode == ST_STRETCH);
  assign corePowerDown   = (r.mode == ST_PIN_PD);

  scan_edge_path uScan (
    .clk         (clk),
    .reset_n     (reset_n),
    .testClk     (testClk),
    .testDataIn  (testDataIn),
    .testModeSel (testModeSel),
    .testResetN  (testResetN),
    .testDataOut (testDataOut)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks; the stretch age counter exists only for them
  logic [STRETCH_CNT_W-1:0] stretchAgeQ;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stretchAgeQ <= '0;
    end else if (r.mode == ST_STRETCH) begin
      stretchAgeQ <= stretchAgeQ + 1'b1;
    end else begin
      stretchAgeQ <= '0;
    end
  end

  AST_REQ_ENTERS_RESET: assert property (@(posedge clk) disable iff (!reset_n)
    (!resetPinN || r.softReset) && r.mode != ST_RESET |=> r.mode == ST_RESET)
    else $error("reset request did not start the reset cycle");
  AST_STRETCH_LENGTH: assert property (@(posedge clk) disable iff (!reset_n)
    r.mode == ST_RUN && $past(r.mode) == ST_STRETCH
      |-> $past(stretchAgeQ) == STRETCH_CNT_W'(STRETCH_CYCLES - 1))
    else $error("reset stretch length wrong");
  AST_PAUSE_FOLLOWS: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 pauseAdvertise == $past(pausePin))
    else $error("pause advertisement does not follow pin");
  AST_PIN_POWER_DOWN: assert property (@(posedge clk) disable iff (!reset_n)
    r.mode == ST_RUN && powerDownPin && !resetReq |=> corePowerDown)
    else $error("power-down pin ignored");
  AST_LAMP_SELECT: assert property (@(posedge clk) disable iff (!reset_n)
    r.mode == ST_RUN && !resetReq && !powerDownPin
      |=> lampCfgOut == $past(lampLevel) && lampCfgOe == 3'h7)
    else $error("lamp output does not show selected condition");
  AST_CFG_LATCH: assert property (@(posedge clk) disable iff (!reset_n)
    r.mode == ST_STRETCH && !resetReq && r.stretchCnt == '0
      |=> r.cfgPins == $past(lampCfgIn) && lampCfgOe == 3'h7)
    else $error("configuration pins not latched at reset end");
  AST_MGMT_LOCK: assert property (@(posedge clk) disable iff (!reset_n)
    r.mgmtDis && r.mode == ST_RUN && wrCfg |=> $stable(hwCfg))
    else $error("configuration written while management disabled");
  AST_RESET_PINS: assert property (@(posedge clk) disable iff (!reset_n)
    r.mode == ST_RESET |-> rxd == 4'h0 && !rxDv && !crs && txClk && rxClk
      && miiOutOe && miiInPullDown && lampCfgOe == 3'h0)
    else $error("pin states wrong during hardware reset");
  AST_SOFT_PWRDN: assert property (@(posedge clk) disable iff (!reset_n)
    r.mode == ST_RUN && r.softPwrDn && !r.isolate
      |-> miiOutOe && rxd == 4'h0 && !col && txClk == $past(coreTxClk))
    else $error("soft power-down pin states wrong");
  AST_FLOAT_MODES: assert property (@(posedge clk) disable iff (!reset_n)
    (r.mode == ST_PIN_PD |-> !miiOutOe && !miiOutPullDown && !miiInPullDown)
    and (r.mode == ST_RUN && r.isolate |-> !miiOutOe && miiOutPullDown))
    else $error("float mode pin states wrong");

  COV_SOFT_RESET: cover property (@(posedge clk) disable iff (!reset_n)
    resetPinN && r.softReset ##1 r.mode == ST_RESET);
  COV_RUN_REACHED: cover property (@(posedge clk) disable iff (!reset_n)
    r.mode == ST_STRETCH ##1 r.mode == ST_RUN);
  COV_PIN_PD: cover property (@(posedge clk) disable iff (!reset_n)
    r.mode == ST_PIN_PD ##1 r.mode == ST_RUN);

endmodule

// File: testbench/mac_side_model.sv
// Receive data pins as the MAC side of the wire resolves them.
// Assumes enable and pull-down come straight from the transceiver.
module mac_side_model (
  // Pins from the transceiver
  input  wire logic [3:0] rxd,
  input  wire logic       miiOutOe,
  input  wire logic       miiOutPullDown,
  // Level seen by the MAC
  output logic      [3:0] rxdSeen
);
  timeunit 1ns;
  timeprecision 100ps;
  // A released line with no pull floats; it never keeps the last value
  assign rxdSeen = miiOutOe ? rxd :
                   (miiOutPullDown ? 4'h0 : 4'bzzzz);
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the reset, power and pin-mode block.
// Assumes a short reset stretch parameter and a single 40 MHz clock.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import phy_ctrl_pkg::*;
  localparam int SC = 8;
  logic clk = 0, reset_n = 0, regWrite = 0, regRead = 0;
  logic [4:0] regAddr = '0;
  logic [15:0] regWrData = '0, regRdData, rdv;
  logic resetPinN = 0, pausePin = 0, powerDownPin = 0, mgmtDisablePin = 0;
  logic [2:0] lampCfgIn = 3'h3, lampCfgOut, lampCfgOe, hwCfg;
  logic [7:0] lampCond = 8'h42;
  logic [3:0] coreRxd = 4'hF, rxd, rxdSeen;
  logic coreRxDv = 1, coreRxEr = 1, coreCol = 1, coreCrs = 1;
  logic coreTxClk = 0, coreRxClk = 0, rxDv, rxEr, col, crs, txClk, rxClk;
  logic miiOutOe, miiOutPullDown, miiInPullDown, pauseAdvertise;
  logic coreResetActive, corePowerDown, testDataOut;
  logic testClk = 0, testDataIn = 0, testModeSel = 0, testResetN = 1;
  int miscompares = 0, testsRun = 0;

  phy_reset_power_pin_modes #(.STRETCH_CYCLES(SC)) dut (
    .clk, .reset_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .resetPinN, .pausePin, .powerDownPin, .mgmtDisablePin, .lampCfgIn,
    .lampCfgOut, .lampCfgOe, .lampCond, .coreRxd, .coreRxDv, .coreRxEr,
    .coreCol, .coreCrs, .coreTxClk, .coreRxClk, .rxd, .rxDv, .rxEr, .col,
    .crs, .txClk, .rxClk, .miiOutOe, .miiOutPullDown, .miiInPullDown,
    .pauseAdvertise, .hwCfg, .coreResetActive, .corePowerDown, .testClk,
    .testDataIn, .testModeSel, .testResetN, .testDataOut);
  mac_side_model mac (.rxd, .miiOutOe, .miiOutPullDown, .rxdSeen);

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, g);
    testsRun++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // Waits n edges, then settles to mid-cycle for sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    regWrite <= 1; regAddr <= a; regWrData <= d;
    @(posedge clk);
    regWrite <= 0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    regRead <= 1; regAddr <= a;
    @(posedge clk);
    regRead <= 0;
    @(negedge clk);
    rdv = regRdData;
  endtask
  task automatic summarize;
    if (miscompares == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    cyc(2);
    chk("rxd", 4'h0, rxd);
    chk("crs", 1'b0, crs);
    chk("txClk", 1'b1, txClk);
    chk("inPd", 1'b1, miiInPullDown);
    chk("rstAct", 1'b1, coreResetActive);
    @(posedge clk) resetPinN <= 1;
    cyc(SC - 1);
    chk("stretch", 1'b1, coreResetActive);
    cyc(3);
    chk("run", 1'b0, coreResetActive);
    chk("hwCfg", 3'h3, hwCfg);
    chk("lampOe", 3'h7, lampCfgOe);
  endtask
  task automatic t_regs;
    @(posedge clk) pausePin <= 1;
    cyc(2);
    chk("pause", 1'b1, pauseAdvertise);
    @(posedge clk) pausePin <= 0;
    cyc(2);
    chk("nopause", 1'b0, pauseAdvertise);
    wr(REG_LAMP_CFG, 16'h0621);
    cyc(3);
    chk("lamps", 3'h5, lampCfgOut);
    wr(REG_HW_CFG, 16'h0006);
    rd(REG_HW_CFG);
    chk("hwWr", 16'h0006, rdv);
    rd(5'h1F);
    chk("unmapped", 16'h0000, rdv);
  endtask
  task automatic t_modes;
    wr(REG_CONTROL, 16'h0800);
    @(posedge clk) coreTxClk <= 1;
    cyc(2);
    chk("sRxd", 4'h0, rxd);
    chk("sClk", 1'b1, txClk);
    chk("sInPd", 1'b1, miiInPullDown);
    wr(REG_CONTROL, 16'h0400);
    cyc(2);
    chk("iOe", 1'b0, miiOutOe);
    chk("iSeen", 4'h0, rxdSeen);
    chk("iInPd", 1'b1, miiInPullDown);
    wr(REG_CONTROL, 16'h0000);
    @(posedge clk) powerDownPin <= 1;
    cyc(3);
    chk("pd", 1'b1, corePowerDown);
    chk("pSeen", 4'bzzzz, rxdSeen);
    chk("pInPd", 1'b0, miiInPullDown);
    @(posedge clk) powerDownPin <= 0;
    cyc(3);
    chk("back", 4'hF, rxdSeen);
  endtask
  task automatic t_soft_scan;
    @(posedge clk) mgmtDisablePin <= 1;
    wr(REG_CONTROL, 16'h8000);
    cyc(2);
    chk("soft", 1'b1, coreResetActive);
    cyc(SC + 4);
    chk("softEnd", 1'b0, coreResetActive);
    // Latched management disable must refuse the configuration write
    wr(REG_HW_CFG, 16'h0006);
    rd(REG_HW_CFG);
    chk("hwLock", 16'h0003, rdv);
    @(posedge clk) begin
      testDataIn <= 1; testClk <= 1;
    end
    cyc(4);
    chk("tdoHold", 1'b0, testDataOut);
    @(posedge clk) testClk <= 0;
    cyc(4);
    chk("tdo", 1'b1, testDataOut);
    @(posedge clk) testResetN <= 0;
    cyc(3);
    chk("trst", 1'b0, testDataOut);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1;
    t_reset();
    t_regs();
    t_modes();
    t_soft_scan();
    summarize();
  end
  initial begin
    #(25 * 3000);
    miscompares++;
    summarize();
  end
endmodule
